//--- tef_params.svh
// Summary of operation
// - each flag pairs with same-position mask bit
// - writing one clears flag, zero keeps
// - overflow flag sets on counter rollover
// - tick flag sets each tick period end
// - low four flag bits read zero
// - two-bit rate field picks tick period
`ifndef TEF_PARAMS_SVH
`define TEF_PARAMS_SVH
`define TEF_ADDR_FLAGS 4'h0
`define TEF_ADDR_MASKS 4'h4
`define TEF_ADDR_PULSE_ACCUM_CONTROL 4'h8
`define TEF_ADDR_COUNT 4'hC
`define TEF_BIT_OVF 7
`define TEF_BIT_TICK 6
`define TEF_FLAG_MASK 8'hF0
`define TEF_RATE_LSB 0
`define TEF_TICK_BASE 16'h2000
`define TEF_COUNT_TOP 16'hFFFF
`define TEF_RST_FLAGS 8'h00
`define TEF_RST_MASKS 8'h00
`define TEF_RST_PULSE_ACCUM_CONTROL 8'h00
`define TEF_RST_COUNT 16'h0000
`define TEF_RESP_OKAY 2'h0
`define TEF_RESP_SLVERR 2'h2
`endif

//--- tef_pkg.sv
package tef_pkg;
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } tef_wreq_s;
   typedef enum logic [1:0] {
      TEF_W_IDLE = 2'b00,
      TEF_W_RESP = 2'b01
   } tef_wstate_e;
endpackage

//--- tef_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "tef_params.svh"
// periodic tick: base period times 1,2,4,8 by rate field
module tef_tick_gen
   import tef_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] rate,
   output logic tick
);
   logic [18:0] cnt_r;
   logic [18:0] cnt_nxt;
   logic [18:0] limit;
   always_comb begin
      limit = ({3'h0, `TEF_TICK_BASE} << rate) - 19'h00001;
      tick = (cnt_r >= limit);
      cnt_nxt = tick ? 19'h00000 : cnt_r + 19'h00001;
   end
   // count restarts at each tick, so a rate change takes effect at once
   always_ff @(posedge aclk) begin
      if (!aresetn) cnt_r <= 19'h00000;
      else cnt_r <= cnt_nxt;
   end
endmodule // tef_tick_gen
`default_nettype wire

//--- tef_timer_flags.sv
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tef_params.svh"
// event flags, masks, free-running counter and tick with AXI4-Lite access
module tef_timer_flags
   import tef_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic timer_irq
);
   // one registered value and one next value per piece of state
   logic [7:0] timer_event_flags_r, timer_event_flags_nxt;
   logic [7:0] timer_event_masks_r, timer_event_masks_nxt;
   logic [7:0] pulse_accum_control_r, pulse_accum_control_nxt;
   logic [15:0] free_running_counter_r, free_running_counter_nxt;
   logic aw_have_r, aw_have_nxt;
   logic w_have_r, w_have_nxt;
   tef_wreq_s wreq_r, wreq_nxt;
   tef_wstate_e wst_r, wst_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic tick;
   logic do_write;
   logic overflow;
   logic irq_nxt;
   logic [7:0] clr;

   // tick source; its period follows the rate field
   tef_tick_gen i_tef_tick_gen (
      .aclk(aclk),
      .aresetn(aresetn),
      .rate(pulse_accum_control_r[`TEF_RATE_LSB +: 2]),
      .tick(tick)
   );

   // byte-lane write helper; registers sit in lane 0
   function automatic logic [7:0] lane0(input logic [7:0] old,
                                        input tef_wreq_s rq);
      lane0 = rq.strb[0] ? rq.data[7:0] : old;
   endfunction

   // true for the four word offsets that hold a register
   function automatic logic addr_mapped(input logic [3:0] a);
      addr_mapped = (a == `TEF_ADDR_FLAGS) || (a == `TEF_ADDR_MASKS) ||
                    (a == `TEF_ADDR_PULSE_ACCUM_CONTROL) || (a == `TEF_ADDR_COUNT);
   endfunction

   // one write at a time, address and data taken in either order
   assign s_axi_awready = (wst_r == TEF_W_IDLE) && !aw_have_r;
   assign s_axi_wready = (wst_r == TEF_W_IDLE) && !w_have_r;
   assign s_axi_bvalid = (wst_r == TEF_W_RESP);
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign do_write = (wst_r == TEF_W_IDLE) && aw_have_r && w_have_r;

   // counter at its top value: the coming edge wraps it to zero
   assign overflow = (free_running_counter_r == `TEF_COUNT_TOP);

   // write channel capture and response
   always_comb begin
      aw_have_nxt = aw_have_r;
      w_have_nxt = w_have_r;
      wreq_nxt = wreq_r;
      wst_nxt = wst_r;
      bresp_nxt = bresp_r;
      // each half is held until the other arrives
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_nxt = 1'b1;
         wreq_nxt.addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_nxt = 1'b1;
         wreq_nxt.data = s_axi_wdata;
         wreq_nxt.strb = s_axi_wstrb;
      end
      case (wst_r)
         TEF_W_IDLE: begin
            if (do_write) begin
               wst_nxt = TEF_W_RESP;
               aw_have_nxt = 1'b0;
               w_have_nxt = 1'b0;
               // unmapped offsets are refused with an error response
               if (addr_mapped(wreq_r.addr))
                  bresp_nxt = `TEF_RESP_OKAY;
               else
                  bresp_nxt = `TEF_RESP_SLVERR;
            end
         end
         TEF_W_RESP: begin
            if (s_axi_bready) wst_nxt = TEF_W_IDLE;
         end
         default: wst_nxt = TEF_W_IDLE;
      endcase
   end

   // register file, counter and flags
   always_comb begin
      timer_event_masks_nxt = timer_event_masks_r;
      pulse_accum_control_nxt = pulse_accum_control_r;
      // counter wraps naturally; it is read-only to software
      free_running_counter_nxt = free_running_counter_r + 16'h0001;
      clr = 8'h00;
      if (do_write) begin
         if (wreq_r.addr == `TEF_ADDR_FLAGS) begin
            // write-one clears; bit six clears tick
            clr = wreq_r.strb[0] ? wreq_r.data[7:0] : 8'h00;
         end else if (wreq_r.addr == `TEF_ADDR_MASKS) begin
            timer_event_masks_nxt = lane0(timer_event_masks_r, wreq_r) &
                                    `TEF_FLAG_MASK;
         end else if (wreq_r.addr == `TEF_ADDR_PULSE_ACCUM_CONTROL) begin
            pulse_accum_control_nxt = lane0(pulse_accum_control_r, wreq_r);
         end
      end
      timer_event_flags_nxt = timer_event_flags_r & ~clr & `TEF_FLAG_MASK;
      // rollover sets overflow; set beats clear
      if (overflow) timer_event_flags_nxt[`TEF_BIT_OVF] = 1'b1;
      if (tick) timer_event_flags_nxt[`TEF_BIT_TICK] = 1'b1;
   end

   // read channel: answer one cycle after address taken
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         // data is captured here, so it stands unchanged until rready
         rresp_nxt = addr_mapped(s_axi_araddr) ? `TEF_RESP_OKAY :
                                                `TEF_RESP_SLVERR;
         if (s_axi_araddr == `TEF_ADDR_FLAGS)
            rdata_nxt = {24'h000000, timer_event_flags_r};
         else if (s_axi_araddr == `TEF_ADDR_MASKS)
            rdata_nxt = {24'h000000, timer_event_masks_r};
         else if (s_axi_araddr == `TEF_ADDR_PULSE_ACCUM_CONTROL)
            rdata_nxt = {24'h000000, pulse_accum_control_r};
         else if (s_axi_araddr == `TEF_ADDR_COUNT)
            rdata_nxt = {16'h0000, free_running_counter_r};
         else begin
            // unmapped offsets read as zero
            rdata_nxt = 32'h00000000;
         end
      end
   end

   // flag gated by same-position mask; level irq
   // built from next values so the registered line adds no lag
   always_comb begin
      irq_nxt = |(timer_event_flags_nxt & timer_event_masks_nxt);
   end

   // write channel registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         wreq_r <= '0;
         wst_r <= TEF_W_IDLE;
         bresp_r <= 2'h0;
      end else begin
         aw_have_r <= aw_have_nxt;
         w_have_r <= w_have_nxt;
         wreq_r <= wreq_nxt;
         wst_r <= wst_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   // software-visible registers, counter and interrupt line
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_event_flags_r <= `TEF_RST_FLAGS;
         timer_event_masks_r <= `TEF_RST_MASKS;
         pulse_accum_control_r <= `TEF_RST_PULSE_ACCUM_CONTROL;
         free_running_counter_r <= `TEF_RST_COUNT;
         timer_irq <= 1'b0;
      end else begin
         timer_event_flags_r <= timer_event_flags_nxt;
         timer_event_masks_r <= timer_event_masks_nxt;
         pulse_accum_control_r <= pulse_accum_control_nxt;
         free_running_counter_r <= free_running_counter_nxt;
         timer_irq <= irq_nxt;
      end
   end

   // read channel registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= 2'h0;
      end else begin
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end
endmodule // tef_timer_flags
`default_nettype wire

//--- tef_timer_flags_properties.sv
`timescale 1ns/1ps
`default_nettype none
// bus handshake and flag read-back checks
module tef_timer_flags_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic timer_irq
);
   logic [3:0] ra_r;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // address of the read now being answered
   always_ff @(posedge aclk)
      if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
   chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
   chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("no rvalid");
   chk_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready while busy");
   chk_wr_block: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("wready while busy");
   chk_rd_done: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid) else $error("rvalid stuck");
   chk_wr_done: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid) else $error("bvalid stuck");
   chk_flag_low: assert property (s_axi_rvalid && ra_r == 4'h0 |->
      s_axi_rdata[3:0] == 4'h0) else $error("flag low bits set");
   // the request may only drop at the edge that commits a write
   chk_irq_hold: assert property ($fell(timer_irq) |->
      $rose(s_axi_bvalid)) else $error("irq dropped without a write");
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   cover property ($rose(timer_irq));
   cover property (s_axi_rvalid && ra_r == 4'h0 && s_axi_rdata[7]);
   cover property (s_axi_rvalid && ra_r == 4'h0 && s_axi_rdata[6]);
endmodule // tef_timer_flags_properties
bind tef_timer_flags tef_timer_flags_properties
   i_tef_timer_flags_properties (
      .aclk(aclk), .aresetn(aresetn), .timer_irq(timer_irq),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp), .s_axi_awready(s_axi_awready),
      .s_axi_wready(s_axi_wready)
   );
`default_nettype wire

//--- tef_timer_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tef_timer_flags_tb;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin \
   miscompares++; $display("wrong value at %0t: %h", $time, a); end end
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, timer_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int miscompares = 0, n_tests = 0, cyc = 0, t0, t1;
   // device under test, every port tied to the bench signal of its name
   tef_timer_flags i_tef_timer_flags (
      .aclk(aclk), .aresetn(aresetn), .timer_irq(timer_irq),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready)
   );
   // clock and a cycle count since reset release
   initial forever #25 aclk = ~aclk;
   always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;
   task results;
      $display("checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // write: address and data offered together, each dropped when taken
   task wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      `CHK(s_axi_bresp, e)
   endtask
   // read: response code and masked data compared together
   task rd(input logic [3:0] a, input logic [33:0] e,
           input logic [31:0] m = 32'hFFFFFFFF);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      `CHK({s_axi_rresp, s_axi_rdata & m}, e)
   endtask
   // irq is sampled at edges, so both ends of a period see the same lag
   task wait_irq;
      while (timer_irq !== 1'h1) @(posedge aclk);
      t1 = t0;
      t0 = cyc;
   endtask
   // hang guard, well past the overflow near 65536 cycles
   initial begin
      #(90000 * 50);
      miscompares++;
      results;
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rd(4'h0, 34'h0);
      rd(4'h2, {2'h2, 32'h0});
      wr(4'h2, 8'h00, 2'h2);
      wr(4'h4, 8'hFF, 2'h0);
      rd(4'h4, 34'hF0);
      // with lane 0 disabled the write must not land
      s_axi_wstrb <= 4'h0;
      wr(4'h4, 8'h00, 2'h0);
      rd(4'h4, 34'hF0);
      s_axi_wstrb <= 4'hF;
      $display("test registers done");
      for (int r = 0; r < 2; r++) begin
         wr(4'h8, 8'(r), 2'h0);
         rd(4'h8, 34'(r));
         wr(4'h0, 8'h40, 2'h0);
         wait_irq;
         rd(4'h0, 34'h40);
         wr(4'h0, 8'h00, 2'h0);
         rd(4'h0, 34'h40);
         wr(4'h0, 8'h40, 2'h0);
         `CHK(timer_irq, 1'h0)
         wait_irq;
         `CHK(t0 - t1, 8192 << r)
         wr(4'h0, 8'h40, 2'h0);
      end
      $display("test tick done");
      wr(4'h4, 8'h80, 2'h0);
      wait_irq;
      `CHK(t0 > 65534 && t0 < 65538, 1'h1)
      rd(4'h0, 34'h80, 32'h80);
      wr(4'h4, 8'h00, 2'h0);
      `CHK(timer_irq, 1'h0)
      wr(4'h0, 8'h80, 2'h0);
      rd(4'h0, 34'h0, 32'h80);
      wr(4'hC, 8'h55, 2'h0);
      // counter equals cycles since reset; read samples it two edges on
      t0 = cyc;
      rd(4'hC, {2'h0, 16'h0, 16'(t0 + 2)});
      $display("test overflow done");
      results;
   end
endmodule // tef_timer_flags_tb
`default_nettype wire
